// file: adc_defs.svh
// Constants for the converter output path and its capture controller.
// Assumes it is included by bare name from the package, the checker and the bench.
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

// ****************************************
// Converter register addresses
// ****************************************
`define ADDR_POWER_MODES 8'h08
`define ADDR_DCS_CTRL 8'h09
`define ADDR_CLOCK_DIVIDE 8'h0b
`define ADDR_OUTPUT_MODE 8'h14
`define ADDR_PATH_STATUS 8'h15
`define ADDR_REQ_CTRL 8'h3c
`define ADDR_REQ_TUNING 8'h3e
`define ADDR_BAND_CENTER 8'h3f

// ****************************************
// Converter fields and reset values
// ****************************************
`define OUT_DISABLE_BIT 4
`define REQ_ENABLE_BIT 0
`define RST_OUTPUT_MODE 8'h01
`define RST_ZERO 8'h00
`define FS_POS 11'h3ff
`define FS_NEG 11'h400
`define SIGN_FLIP 11'h400
`define REQ_GAIN_Q8 20'h000ef
`define TUNE_MAX_22 6'h38
`define TUNE_MAX_33 6'h21
`define BAND_HALF_22 8'h16
`define BAND_HALF_33 8'h21

// ****************************************
// Timing
// ****************************************
`define CLOCK_PERIOD_NS 50
`define RELOCK_MIN_NS 1500
`define RELOCK_MAX_NS 5000
`define RELOCK_DEV_CYCLES ((`RELOCK_MIN_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define RELOCK_HOST_CYCLES ((`RELOCK_MAX_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define DCS_MIN_MHZ 40
`define LAT_PLAIN 10
`define LAT_REQ 13
`define LAT_OVERRANGE 10
`define WAKE_DOWN_CYCLES 5'h10
`define WAKE_STANDBY_CYCLES 5'h04

// ****************************************
// Controller register addresses and AXI response codes
// ****************************************
`define HOST_CMD 8'h00
`define HOST_STATUS 8'h04
`define HOST_SAMPLE 8'h08
`define HOST_COUNT 8'h0c
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// file: adc_pkg.sv
// Types shared by the converter output path and its capture controller.
// Assumes the constants header sits in the same folder.
package adc_pkg;
`include "adc_defs.svh"

   typedef logic [10:0] sample_t;
   typedef logic [7:0] reg_byte_t;

   typedef enum logic [1:0] {
      PWR_NORMAL = 2'h0,
      PWR_DOWN = 2'h1,
      PWR_STANDBY = 2'h2,
      PWR_SPARE = 2'h3
   } power_mode_t;

   typedef enum logic [1:0] {
      FMT_OFFSET = 2'h0,
      FMT_TWOS = 2'h1,
      FMT_GRAY = 2'h2,
      FMT_SPARE = 2'h3
   } out_format_t;

   typedef enum logic [1:0] {
      H_IDLE = 2'h0,
      H_WAIT = 2'h1,
      H_SETTLE = 2'h2
   } host_state_t;
endpackage

// file: adc_link_if.sv
// Link between the converter output path and the capture controller.
// Assumes both ends run on one clock; the host captures samples only while sample_oe is high.
`timescale 1ns/1ps
interface adc_link_if;
   adc_pkg::sample_t sample_data;
   logic sample_oe;
   logic overrange;
   logic data_clock_out;
   logic reg_req;
   logic reg_we;
   adc_pkg::reg_byte_t reg_addr;
   adc_pkg::reg_byte_t reg_wdata;
   adc_pkg::reg_byte_t reg_rdata;
   logic reg_ack;

   modport device_end (
      output sample_data,
      output sample_oe,
      output overrange,
      output data_clock_out,
      input reg_req,
      input reg_we,
      input reg_addr,
      input reg_wdata,
      output reg_rdata,
      output reg_ack
   );

   modport host_end (
      input sample_data,
      input sample_oe,
      input overrange,
      input data_clock_out,
      output reg_req,
      output reg_we,
      output reg_addr,
      output reg_wdata,
      input reg_rdata,
      input reg_ack
   );
endinterface

// file: adc_output_path.sv
// Converter digital control and output path: divider, stabilizer, power, requantizer, format.
// Assumes raw samples arrive on clock and the register port is driven by the capture controller.
`timescale 1ns/1ps
module adc_output_path #(
   parameter int INPUT_CLOCK_MHZ = 20
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic signed [11:0] adc_raw,
   output logic reference_on,
   output logic dcs_locked,
   adc_link_if.device_end link
);
   import adc_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      reg_byte_t power_modes;
      reg_byte_t dcs_ctrl;
      reg_byte_t clock_divide;
      reg_byte_t output_mode;
      reg_byte_t req_ctrl;
      reg_byte_t req_tuning;
      logic dcs_written;
      logic [2:0] div_cnt;
      logic [6:0] relock_cnt;
      logic [4:0] wake_cnt;
      logic [`LAT_REQ-1:0][10:0] data_pipe;
      logic [`LAT_REQ-1:0] or_pipe;
      logic [7:0] req_residue;
      sample_t sample_data;
      logic sample_oe;
      logic overrange;
      logic data_clock_out;
      logic reference_on;
      logic dcs_locked;
      reg_byte_t reg_rdata;
      logic reg_ack;
   } dev_state_t;

   dev_state_t s_r;
   dev_state_t s_nxt;
   power_mode_t pmode;
   logic running;
   logic tick;
   logic dcs_on;
   logic dcs_usable;
   logic bw33;
   logic req_on;
   logic over;
   logic signed [10:0] clipped;
   logic signed [19:0] product;
   sample_t stage0;
   sample_t tap;
   sample_t offset_code;
   sample_t formatted;
   logic [5:0] tune_limit;
   reg_byte_t band_center;
   reg_byte_t status;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.reg_ack = 1'b0;
      pmode = power_mode_t'(s_r.power_modes[1:0]);
      running = (pmode != PWR_DOWN) && (pmode != PWR_STANDBY) && (s_r.wake_cnt == 5'h00);
      tick = running && (s_r.div_cnt == s_r.clock_divide[2:0]);

      if (!running || tick) begin
         s_nxt.div_cnt = 3'h0;
      end else begin
         s_nxt.div_cnt = 3'(s_r.div_cnt + 3'h1);
      end

      if (pmode == PWR_DOWN) begin
         s_nxt.wake_cnt = `WAKE_DOWN_CYCLES;
      end else if (pmode == PWR_STANDBY) begin
         s_nxt.wake_cnt = `WAKE_STANDBY_CYCLES;
      end else if (s_r.wake_cnt != 5'h00) begin
         s_nxt.wake_cnt = 5'(s_r.wake_cnt - 5'h01);
      end

      if (s_r.relock_cnt != 7'h00) begin
         s_nxt.relock_cnt = 7'(s_r.relock_cnt - 7'h01);
      end

      // Stabilizer state.
      dcs_on = s_r.dcs_written ? s_r.dcs_ctrl[0] : (s_r.clock_divide[2:0] != 3'h0);
      dcs_usable = (INPUT_CLOCK_MHZ / (int'(s_r.clock_divide[2:0]) + 1)) >= `DCS_MIN_MHZ;
      s_nxt.dcs_locked = dcs_on && dcs_usable && (s_nxt.relock_cnt == 7'h00);

      // Requantizer band and tuning.
      req_on = s_r.req_ctrl[`REQ_ENABLE_BIT];
      bw33 = (s_r.req_ctrl[3:1] == 3'h1);
      tune_limit = bw33 ? `TUNE_MAX_33 : `TUNE_MAX_22;
      band_center = {2'h0, s_r.req_tuning[5:0]} + (bw33 ? `BAND_HALF_33 : `BAND_HALF_22);
      status = {4'h0, (s_r.req_tuning[5:0] <= tune_limit), running, (s_r.relock_cnt != 7'h00),
                s_r.dcs_locked};

      // ****************************************
      // Register port
      // ****************************************
      if (link.reg_req) begin
         s_nxt.reg_ack = 1'b1;
         if (link.reg_we) begin
            if (link.reg_addr == `ADDR_POWER_MODES) begin
               s_nxt.power_modes = link.reg_wdata;
            end else if (link.reg_addr == `ADDR_DCS_CTRL) begin
               s_nxt.dcs_ctrl = link.reg_wdata;
               s_nxt.dcs_written = 1'b1;
            end else if (link.reg_addr == `ADDR_CLOCK_DIVIDE) begin
               s_nxt.clock_divide = {5'h00, link.reg_wdata[2:0]};
               if (link.reg_wdata[2:0] != s_r.clock_divide[2:0]) begin
                  s_nxt.relock_cnt = 7'(`RELOCK_DEV_CYCLES);
                  s_nxt.dcs_locked = 1'b0;
               end
            end else if (link.reg_addr == `ADDR_OUTPUT_MODE) begin
               s_nxt.output_mode = link.reg_wdata;
            end else if (link.reg_addr == `ADDR_REQ_CTRL) begin
               s_nxt.req_ctrl = link.reg_wdata;
            end else if (link.reg_addr == `ADDR_REQ_TUNING) begin
               s_nxt.req_tuning = {2'h0, link.reg_wdata[5:0]};
            end
         end else begin
            if (link.reg_addr == `ADDR_POWER_MODES) begin
               s_nxt.reg_rdata = s_r.power_modes;
            end else if (link.reg_addr == `ADDR_DCS_CTRL) begin
               s_nxt.reg_rdata = {7'h00, dcs_on};
            end else if (link.reg_addr == `ADDR_CLOCK_DIVIDE) begin
               s_nxt.reg_rdata = s_r.clock_divide;
            end else if (link.reg_addr == `ADDR_OUTPUT_MODE) begin
               s_nxt.reg_rdata = s_r.output_mode;
            end else if (link.reg_addr == `ADDR_PATH_STATUS) begin
               s_nxt.reg_rdata = status;
            end else if (link.reg_addr == `ADDR_REQ_CTRL) begin
               s_nxt.reg_rdata = s_r.req_ctrl;
            end else if (link.reg_addr == `ADDR_REQ_TUNING) begin
               s_nxt.reg_rdata = s_r.req_tuning;
            end else if (link.reg_addr == `ADDR_BAND_CENTER) begin
               s_nxt.reg_rdata = band_center;
            end else begin
               s_nxt.reg_rdata = `RST_ZERO;
            end
         end
      end

      // ****************************************
      // Sample path
      // ****************************************
      over = (adc_raw > 12'sh3ff) || (adc_raw < -12'sh400);
      if (adc_raw > 12'sh3ff) begin
         clipped = `FS_POS;
      end else if (adc_raw < -12'sh400) begin
         clipped = `FS_NEG;
      end else begin
         clipped = adc_raw[10:0];
      end
      product = 20'(clipped) * $signed(`REQ_GAIN_Q8) + $signed({12'h000, s_r.req_residue});
      stage0 = req_on ? product[18:8] : clipped;
      tap = req_on ? s_r.data_pipe[`LAT_REQ-1] : s_r.data_pipe[`LAT_PLAIN-1];
      offset_code = tap ^ `SIGN_FLIP;
      case (out_format_t'(s_r.output_mode[1:0]))
         FMT_OFFSET: formatted = offset_code;
         FMT_GRAY: formatted = offset_code ^ (offset_code >> 1);
         default: formatted = tap;
      endcase

      if (tick) begin
         s_nxt.req_residue = req_on ? product[7:0] : 8'h00;
         s_nxt.data_pipe[0] = stage0;
         s_nxt.or_pipe[0] = over;
         for (int i = 1; i < `LAT_REQ; i++) begin
            s_nxt.data_pipe[i] = s_r.data_pipe[i-1];
            s_nxt.or_pipe[i] = s_r.or_pipe[i-1];
         end
         s_nxt.sample_data = formatted;
         s_nxt.overrange = s_r.or_pipe[`LAT_OVERRANGE-1];
         s_nxt.data_clock_out = ~s_r.data_clock_out;
      end

      s_nxt.sample_oe = (pmode != PWR_DOWN) && !s_nxt.output_mode[`OUT_DISABLE_BIT];
      s_nxt.reference_on = (pmode != PWR_DOWN);
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clock) begin
      if (!nrst) begin
         s_r <= '0;
         s_r.output_mode <= `RST_OUTPUT_MODE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.sample_data = s_r.sample_data;
   assign link.sample_oe = s_r.sample_oe;
   assign link.overrange = s_r.overrange;
   assign link.data_clock_out = s_r.data_clock_out;
   assign link.reg_rdata = s_r.reg_rdata;
   assign link.reg_ack = s_r.reg_ack;
   assign reference_on = s_r.reference_on;
   assign dcs_locked = s_r.dcs_locked;
endmodule

// file: adc_capture_host.sv
// Capture controller: AXI4-Lite slave that programs the converter and captures its samples.
// Assumes the converter end shares clock and answers each register request one cycle later.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module adc_capture_host (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output adc_pkg::sample_t captured_sample,
   output logic captured_overrange,
   output logic captured_valid,
   adc_link_if.host_end link
);
   import adc_pkg::*;

   typedef struct packed {
      host_state_t fsm;
      logic aw_held;
      logic w_held;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic bw33;
      logic refused;
      logic relock_after;
      logic [6:0] settle_cnt;
      reg_byte_t read_back;
      logic reg_req;
      logic reg_we;
      reg_byte_t reg_addr;
      reg_byte_t reg_wdata;
      logic dco_prev;
      sample_t cap_sample;
      logic cap_or;
      logic cap_valid;
      logic [31:0] count;
   } host_state_s_t;

   host_state_s_t s_r;
   host_state_s_t s_nxt;
   logic [5:0] limit;
   logic [31:0] status;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.reg_req = 1'b0;
      s_nxt.cap_valid = 1'b0;
      limit = s_r.bw33 ? `TUNE_MAX_33 : `TUNE_MAX_22;
      status = {16'h0000, s_r.read_back, 6'h00, s_r.refused, (s_r.fsm != H_IDLE)};

      // Write channel.
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.aw_held && s_r.w_held) begin
         s_nxt.aw_held = 1'b0;
         s_nxt.w_held = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = `AXI_OKAY;
         if (s_r.awaddr == `HOST_CMD) begin
            if (s_r.fsm != H_IDLE) begin
               s_nxt.refused = 1'b1;
            end else if (s_r.wdata[16] && (s_r.wdata[7:0] == `ADDR_REQ_TUNING) &&
                         (s_r.wdata[13:8] > limit)) begin
               s_nxt.refused = 1'b1;
            end else begin
               s_nxt.reg_req = 1'b1;
               s_nxt.reg_we = s_r.wdata[16];
               s_nxt.reg_addr = s_r.wdata[7:0];
               s_nxt.reg_wdata = s_r.wdata[15:8];
               s_nxt.fsm = H_WAIT;
               s_nxt.relock_after = s_r.wdata[16] && ((s_r.wdata[7:0] == `ADDR_CLOCK_DIVIDE) ||
                                    (s_r.wdata[7:0] == `ADDR_DCS_CTRL));
               if (s_r.wdata[16] && (s_r.wdata[7:0] == `ADDR_REQ_CTRL)) begin
                  s_nxt.bw33 = (s_r.wdata[11:9] == 3'h1);
               end
            end
         end else if (s_r.awaddr == `HOST_STATUS) begin
            if (s_r.wdata[1]) begin
               s_nxt.refused = 1'b0;
            end
         end else begin
            s_nxt.bresp = `AXI_SLVERR;
         end
      end
      if (s_axi_awvalid && s_r.awready) begin
         s_nxt.aw_held = 1'b1;
         s_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_r.wready) begin
         s_nxt.w_held = 1'b1;
         s_nxt.wdata = s_axi_wdata;
      end
      s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
      s_nxt.wready = !s_nxt.w_held && !s_nxt.bvalid;

      // Read channel.
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = `AXI_OKAY;
         if (s_axi_araddr == `HOST_STATUS) begin
            s_nxt.rdata = status;
         end else if (s_axi_araddr == `HOST_SAMPLE) begin
            s_nxt.rdata = {15'h0000, s_r.cap_or, 5'h00, s_r.cap_sample};
         end else if (s_axi_araddr == `HOST_COUNT) begin
            s_nxt.rdata = s_r.count;
         end else if (s_axi_araddr == `HOST_CMD) begin
            s_nxt.rdata = {15'h0000, s_r.reg_we, s_r.reg_wdata, s_r.reg_addr};
         end else begin
            s_nxt.rdata = 32'h00000000;
            s_nxt.rresp = `AXI_SLVERR;
         end
      end
      s_nxt.arready = !s_nxt.rvalid;

      // ****************************************
      // Converter register sequencer
      // ****************************************
      case (s_r.fsm)
         H_WAIT: begin
            if (link.reg_ack) begin
               s_nxt.read_back = link.reg_rdata;
               if (s_r.relock_after) begin
                  s_nxt.settle_cnt = 7'(`RELOCK_HOST_CYCLES);
                  s_nxt.fsm = H_SETTLE;
               end else begin
                  s_nxt.fsm = H_IDLE;
               end
            end
         end
         H_SETTLE: begin
            s_nxt.settle_cnt = 7'(s_r.settle_cnt - 7'h01);
            if (s_r.settle_cnt == 7'h01) begin
               s_nxt.fsm = H_IDLE;
            end
         end
         default: begin
         end
      endcase

      // ****************************************
      // Sample capture
      // ****************************************
      s_nxt.dco_prev = link.data_clock_out;
      if ((link.data_clock_out != s_r.dco_prev) && link.sample_oe) begin
         s_nxt.cap_sample = link.sample_data;
         s_nxt.cap_or = link.overrange;
         s_nxt.cap_valid = 1'b1;
         s_nxt.count = 32'(s_r.count + 32'h1);
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         s_r <= '0;
         s_r.fsm <= H_IDLE;
         s_r.awready <= 1'b1;
         s_r.wready <= 1'b1;
         s_r.arready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign s_axi_rvalid = s_r.rvalid;
   assign captured_sample = s_r.cap_sample;
   assign captured_overrange = s_r.cap_or;
   assign captured_valid = s_r.cap_valid;
   assign link.reg_req = s_r.reg_req;
   assign link.reg_we = s_r.reg_we;
   assign link.reg_addr = s_r.reg_addr;
   assign link.reg_wdata = s_r.reg_wdata;
endmodule

// file: adc_link_chk.sv
// Checker for the converter link: register answers, output enable and sample timing.
// Assumes one clock and the link signals wired in by name.
`timescale 1ns/1ps
`include "adc_defs.svh"
module adc_link_chk (
   input wire logic clock,
   input wire logic nrst,
   input wire adc_pkg::sample_t sample_data,
   input wire logic sample_oe,
   input wire logic overrange,
   input wire logic data_clock_out,
   input wire logic reg_req,
   input wire logic reg_we,
   input wire adc_pkg::reg_byte_t reg_addr,
   input wire adc_pkg::reg_byte_t reg_wdata,
   input wire adc_pkg::reg_byte_t reg_rdata,
   input wire logic reg_ack
);
   import adc_pkg::*;
   // *********
   // Shadow of the settings sent.
   // *********
   logic [5:0] tune_r;
   logic wide_r;
   logic twos_r;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         tune_r <= 6'h00;
         wide_r <= 1'b0;
         twos_r <= 1'b1;
      end else if (reg_req && reg_we) begin
         if (reg_addr == `ADDR_REQ_TUNING) tune_r <= reg_wdata[5:0];
         if (reg_addr == `ADDR_OUTPUT_MODE) twos_r <= reg_wdata[0];
         if (reg_addr == `ADDR_REQ_CTRL) wide_r <= reg_wdata[3:1] == 3'h1;
      end
   end
   logic [7:0] gap_r;
   always_ff @(posedge clock) begin
      if (!nrst) gap_r <= 8'hff;
      else if (reg_req && reg_we && reg_addr == `ADDR_CLOCK_DIVIDE) gap_r <= 8'h00;
      else if (gap_r != 8'hff) gap_r <= gap_r + 8'h01;
   end
   // *********
   // Assertions.
   // *********
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence s_wr(a);
      reg_req && reg_we && reg_addr == a;
   endsequence
   property p_ack;
      reg_req |=> reg_ack ##1 !reg_ack;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not single");
   property p_down;
      s_wr(`ADDR_POWER_MODES) ##0 reg_wdata[1:0] == 2'h1 |-> ##[1:3] !sample_oe;
   endproperty
   a_down: assert property (p_down) else $error("drivers on when down");
   property p_still;
      s_wr(`ADDR_POWER_MODES) ##0 reg_wdata[1:0] == 2'h2 |-> ##3 $stable(data_clock_out) [*8];
   endproperty
   a_still: assert property (p_still) else $error("ticks in standby");
   property p_oeb;
      s_wr(`ADDR_OUTPUT_MODE) ##0 reg_wdata[`OUT_DISABLE_BIT] |-> ##[1:3] !sample_oe;
   endproperty
   a_oeb: assert property (p_oeb) else $error("drivers on when disabled");
   property p_data;
      $changed(sample_data) |-> $changed(data_clock_out);
   endproperty
   a_data: assert property (p_data) else $error("data moved off a tick");
   property p_flag;
      $changed(overrange) |-> $changed(data_clock_out);
   endproperty
   a_flag: assert property (p_flag) else $error("flag moved off a tick");
   property p_clip;
      $changed(data_clock_out) && overrange && twos_r |-> sample_data inside {`FS_POS, `FS_NEG};
   endproperty
   a_clip: assert property (p_clip) else $error("overrange not clipped");
   property p_centre;
      reg_ack && !reg_we && reg_addr == `ADDR_BAND_CENTER |->
         reg_rdata == {2'h0, tune_r} + (wide_r ? `BAND_HALF_33 : `BAND_HALF_22);
   endproperty
   a_centre: assert property (p_centre) else $error("band centre wrong");
   property p_relock;
      reg_req && gap_r != 8'hff |-> gap_r >= `RELOCK_HOST_CYCLES;
   endproperty
   a_relock: assert property (p_relock) else $error("request inside relock wait");
endmodule

// file: tb_adc_digital_output_path.sv
// Bench for the converter output path and its capture controller on one link.
// Assumes the package, interface, design files and checker compile first.
`timescale 1ns/1ps
`include "adc_defs.svh"
module tb_adc_digital_output_path;
   import adc_pkg::*;
   logic clock, nrst, awv, wv, arv, bready, rready, awready, wready, arready, bvalid, rvalid;
   logic cap_v, cap_o, ref_on, locked;
   logic [1:0] bresp, rresp, r;
   logic [7:0] awa, ara;
   logic [31:0] wd, rd, s;
   logic [11:0] raw;
   sample_t cap_s;
   int n_errors, cmp_count;
   always #25 clock = ~clock;
   adc_link_if lnk ();
   adc_output_path i_adc_output_path (.clock(clock), .nrst(nrst), .adc_raw(raw),
      .reference_on(ref_on), .dcs_locked(locked), .link(lnk));
   adc_capture_host i_adc_capture_host (.clock(clock), .nrst(nrst), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arready),
      .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .captured_sample(cap_s), .captured_overrange(cap_o), .captured_valid(cap_v), .link(lnk));
   adc_link_chk i_adc_link_chk (.clock(clock), .nrst(nrst), .sample_data(lnk.sample_data),
      .sample_oe(lnk.sample_oe), .overrange(lnk.overrange), .data_clock_out(lnk.data_clock_out),
      .reg_req(lnk.reg_req), .reg_we(lnk.reg_we), .reg_addr(lnk.reg_addr),
      .reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata), .reg_ack(lnk.reg_ack));
   // *********
   // Shared tasks.
   // *********
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tmo(input int n, input int lim);
      if (n >= lim) begin
         n_errors++;
         test_done();
      end
   endtask
   task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      awa <= a;
      ara <= a;
      wd <= d;
      awv <= w;
      wv <= w;
      arv <= !w;
      bready <= w;
      rready <= !w;
      do begin
         @(posedge clock);
         if (awready) awv <= 1'b0;
         if (wready) wv <= 1'b0;
         if (arready) arv <= 1'b0;
         n++;
      end while ((w ? bvalid : rvalid) !== 1'b1 && n < 50);
      tmo(n, 50);
      s = rd;
      r = w ? bresp : rresp;
      bready <= 1'b0;
      rready <= 1'b0;
   endtask
   task automatic dev(input logic [7:0] a, input logic [7:0] d, input logic w);
      int n;
      n = 0;
      axi(1'b1, `HOST_CMD, {15'h0, w, d, a});
      do begin
         axi(1'b0, `HOST_STATUS, 32'h0);
         n++;
      end while (s[0] !== 1'b0 && n < 100);
      tmo(n, 100);
   endtask
   task automatic probe(input logic [11:0] v, input int lat, input sample_t d, input logic o);
      sample_t base;
      int n;
      base = lnk.sample_data;
      n = 1;
      raw <= v;
      @(posedge clock);
      raw <= 12'h000;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (lnk.sample_data === base && n < 40);
      check("lat", n, lat + 1);
      check("data", lnk.sample_data, d);
      check("or", lnk.overrange, o);
      n = 0;
      while (cap_s !== d && n < 4) begin
         @(posedge clock);
         #1;
         n++;
      end
      check("cap", {cap_v, cap_o, cap_s}, {1'b1, o, d});
      repeat (20) @(posedge clock);
   endtask
   // *********
   // Scenarios.
   // *********
   task automatic t_reg();
      dev(`ADDR_OUTPUT_MODE, 8'h00, 1'b0);
      check("mode reset", s[15:8], `RST_OUTPUT_MODE);
      axi(1'b0, 8'h10, 32'h0);
      check("unmapped", r, `AXI_SLVERR);
      axi(1'b1, 8'h10, 32'h0);
      check("unmapped wr", r, `AXI_SLVERR);
      $display("reg done");
   endtask
   task automatic t_sample();
      probe(12'h123, `LAT_PLAIN, 11'h123, 1'b0);
      probe(12'h500, `LAT_PLAIN, `FS_POS, 1'b1);
      probe(12'ha24, `LAT_PLAIN, `FS_NEG, 1'b1);
      dev(`ADDR_OUTPUT_MODE, 8'h00, 1'b1);
      probe(12'h3ff, `LAT_PLAIN, 11'h7ff, 1'b0);
      dev(`ADDR_OUTPUT_MODE, 8'h02, 1'b1);
      probe(12'h3ff, `LAT_PLAIN, 11'h400, 1'b0);
      dev(`ADDR_OUTPUT_MODE, 8'h01, 1'b1);
      $display("sample done");
   endtask
   task automatic t_power();
      dev(`ADDR_POWER_MODES, 8'h01, 1'b1);
      check("oe", lnk.sample_oe, 1'b0);
      check("ref", ref_on, 1'b0);
      dev(`ADDR_POWER_MODES, 8'h02, 1'b1);
      check("ref", ref_on, 1'b1);
      dev(`ADDR_POWER_MODES, 8'h00, 1'b1);
      dev(`ADDR_OUTPUT_MODE, 8'h11, 1'b1);
      check("oe", lnk.sample_oe, 1'b0);
      dev(`ADDR_OUTPUT_MODE, 8'h01, 1'b1);
      repeat (20) @(posedge clock);
      check("oe", lnk.sample_oe, 1'b1);
      $display("power done");
   endtask
   task automatic t_requant();
      dev(`ADDR_REQ_CTRL, 8'h00, 1'b1);
      dev(`ADDR_REQ_TUNING, 8'h38, 1'b1);
      check("refused", s[1], 1'b0);
      dev(`ADDR_BAND_CENTER, 8'h00, 1'b0);
      check("centre", s[15:8], 8'h4e);
      dev(`ADDR_REQ_TUNING, 8'h39, 1'b1);
      check("refused", s[1], 1'b1);
      axi(1'b1, `HOST_STATUS, 32'h2);
      dev(`ADDR_REQ_CTRL, 8'h03, 1'b1);
      dev(`ADDR_REQ_TUNING, 8'h22, 1'b1);
      check("refused", s[1], 1'b1);
      axi(1'b1, `HOST_STATUS, 32'h2);
      dev(`ADDR_REQ_TUNING, 8'h21, 1'b1);
      check("refused", s[1], 1'b0);
      dev(`ADDR_BAND_CENTER, 8'h00, 1'b0);
      check("centre", s[15:8], 8'h42);
      probe(12'h100, `LAT_REQ, 11'h0ef, 1'b0);
      $display("requant done");
   endtask
   task automatic t_divide();
      int n;
      logic e;
      dev(`ADDR_CLOCK_DIVIDE, 8'h07, 1'b1);
      dev(`ADDR_DCS_CTRL, 8'h00, 1'b0);
      check("dcs", s[8], 1'b1);
      check("lock", locked, 1'b0);
      dev(`ADDR_PATH_STATUS, 8'h00, 1'b0);
      check("status", s[15:8], 8'h0c);
      dev(`ADDR_DCS_CTRL, 8'h00, 1'b1);
      dev(`ADDR_DCS_CTRL, 8'h00, 1'b0);
      check("dcs off", s[8], 1'b0);
      for (int i = 0; i < 2; i++) begin
         n = 0;
         e = lnk.data_clock_out;
         do begin
            @(posedge clock);
            #1;
            n++;
         end while (lnk.data_clock_out === e && n < 20);
      end
      check("tick", n, 8);
      $display("divide done");
   endtask
   initial begin
      clock = 1'b0;
      nrst = 1'b0;
      {awv, wv, arv, bready, rready} = 5'h00;
      {awa, ara, wd, raw} = 60'h0;
      n_errors = 0;
      cmp_count = 0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      t_reg();
      t_sample();
      t_power();
      t_requant();
      t_divide();
      test_done();
   end
endmodule
